// [src/ppp_pkg.sv]
package ppp_pkg;
  // register locations on the two address lines
  localparam logic [1:0] ADDR_DATA    = 2'h0;
  localparam logic [1:0] ADDR_STATUS  = 2'h1;
  localparam logic [1:0] ADDR_CONTROL = 2'h2;
  localparam logic [1:0] ADDR_INVALID = 2'h3;
  // control field positions
  localparam int CTL_STROBE  = 0;
  localparam int CTL_AUTOFD  = 1;
  localparam int CTL_INIT    = 2;
  localparam int CTL_SELIN   = 3;
  localparam int CTL_IRQ_EN  = 4;
  // status field positions
  localparam int STS_ERROR   = 3;
  localparam int STS_SELECT  = 4;
  localparam int STS_PAPER   = 5;
  localparam int STS_ACK     = 6;
  localparam int STS_BUSY    = 7;
  // constant fill bits and reset values
  localparam logic [2:0] STS_LOW_ONES  = 3'h7;
  localparam logic [2:0] CTL_HIGH_ONES = 3'h7;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [4:0] CTL_RESET     = 5'h00;
  // input synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage

// [src/ppp_sync.sv]
`timescale 1ns/1ns
// three-stage synchroniser; output updates once stages two and three agree
module ppp_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,   // system clock
  input  wire logic             reset,  // synchronous, active high
  input  wire logic [WIDTH-1:0] d,      // asynchronous input
  output logic      [WIDTH-1:0] q       // filtered level
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // shift chain; s1 is read by s2 only
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per bit: accept a change only when the two later stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (reset) begin
          q[i] <= 1'b0;
        end else if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule

// [src/ppp_port.sv]
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Function
// RULE1 - registers respond only while printer_port_select is low
// RULE2 - reads: 0 data, 1 status, 2 control; writes: 0 data, 2 control
// RULE3 - data read returns the eight parallel data lines as sensed
// RULE4 - data write drives the written byte onto the data lines
// RULE5 - status read returns ones in bits 0 to 2
// RULE6 - status bits 3..7: error, selected, paper end, acknowledge, busy
// RULE7 - control bits 0..3 report strobe, autofeed, init, select-in lines
// RULE8 - control bit 4 enables printer_interrupt and reads back
// RULE9 - control read returns ones in bits 5 to 7
// RULE10 - control write uses the read layout for lines and enable
// RULE11 - printer_output_enable high floats every printer pin
// RULE12 - write strobe stores bus data into the addressed register
// RULE13 - values stay latched; invalid writes change nothing
module ppp_port (
  input  wire logic       mclk,                  // 100 MHz clock
  input  wire logic       reset,                 // synchronous, active high
  input  wire logic       printer_port_select_n, // port select, active low
  input  wire logic [1:0] addr,                  // register address
  input  wire logic       host_read_strobe_n,    // read strobe, active low
  input  wire logic       host_write_strobe_n,   // write strobe, active low
  input  wire logic [7:0] host_data_in,          // host bus, write data
  output logic      [7:0] host_data_out,         // host bus, read data
  output logic            host_data_oe,          // host bus drive enable
  input  wire logic [7:0] pdata_in,              // parallel data, sensed
  output logic      [7:0] pdata_out,             // parallel data, driven
  output logic            pdata_oe,              // parallel data enable
  output logic      [3:0] pctl_out,              // strobe/autofd/init/selin
  output logic            pctl_oe,               // control lines enable
  input  wire logic [3:0] pctl_in,               // control lines, sensed
  input  wire logic       error_line,            // printer error
  input  wire logic       select_line,           // printer selected
  input  wire logic       paper_end_line,        // paper end
  input  wire logic       ack_line,              // acknowledge
  input  wire logic       busy_line,             // busy
  input  wire logic       printer_output_enable_n, // high floats the pins
  output logic            printer_interrupt,     // gated interrupt
  output logic            printer_interrupt_oe   // interrupt drive enable
);
  //////////////////////////////////////////////////////////////////////////
  // synchronised inputs from pins
  logic [20:0] raw_in;
  logic [20:0] sync_in;
  logic [7:0]  data_s;
  logic [3:0]  ctl_s;
  logic [4:0]  sts_s;
  logic        sel_n_s;
  logic        rd_n_s;
  logic        wr_n_s;
  logic        oe_n_s;
  logic        wr_n_d;

  // active-low pins are inverted ahead of the chain so the cleared chain reads
  // as idle: no false write edge and no pin drive straight after reset
  assign raw_in = {!printer_output_enable_n, !host_write_strobe_n,
                   !host_read_strobe_n, !printer_port_select_n, busy_line, ack_line,
                   paper_end_line, select_line, error_line, pctl_in, pdata_in};

  ppp_sync #(.WIDTH(21)) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .d     (raw_in),
    .q     (sync_in)
  );

  assign data_s  = sync_in[7:0];
  assign ctl_s   = sync_in[11:8];
  assign sts_s   = sync_in[16:12];
  assign sel_n_s = !sync_in[17];
  assign rd_n_s  = !sync_in[18];
  assign wr_n_s  = !sync_in[19];
  assign oe_n_s  = !sync_in[20];

  //////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] out_data;
  logic [4:0] ctl;
  logic       wr_fire;

  // store on the rising edge of the write strobe, so data is settled
  assign wr_fire = !sel_n_s && wr_n_s && !wr_n_d; // RULE1 RULE12

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_n_d <= 1'b1;
    end else begin
      wr_n_d <= wr_n_s;
    end
  end

  // host_data_in is stable by strobe release; sampled directly at that edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      out_data <= ppp_pkg::DATA_RESET;
    end else if (wr_fire && addr == ppp_pkg::ADDR_DATA) begin // RULE2 RULE4
      out_data <= host_data_in;
    end // RULE13
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctl <= ppp_pkg::CTL_RESET;
    end else if (wr_fire && addr == ppp_pkg::ADDR_CONTROL) begin // RULE2 RULE10
      ctl <= host_data_in[4:0];
    end // RULE13
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drive; all printer pins float while the enable pin is high
  assign pdata_out = out_data; // RULE4
  assign pdata_oe  = !oe_n_s;  // RULE11
  assign pctl_out  = ctl[3:0]; // RULE10
  assign pctl_oe   = !oe_n_s;  // RULE11

  // interrupt: acknowledge pulse gated by the enable bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      printer_interrupt    <= 1'b0;
      printer_interrupt_oe <= 1'b0;
    end else begin
      printer_interrupt    <= ctl[ppp_pkg::CTL_IRQ_EN] & sts_s[ppp_pkg::STS_ACK-3]; // RULE8
      printer_interrupt_oe <= ctl[ppp_pkg::CTL_IRQ_EN] & !oe_n_s; // RULE8 RULE11
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux; invalid location returns zero (undefined in the device)
  logic [7:0] next_rd;
  always_comb begin
    unique case (addr)
      ppp_pkg::ADDR_DATA:    next_rd = data_s; // RULE3
      ppp_pkg::ADDR_STATUS:  next_rd = {sts_s, ppp_pkg::STS_LOW_ONES}; // RULE5 RULE6
      ppp_pkg::ADDR_CONTROL: next_rd = {ppp_pkg::CTL_HIGH_ONES, ctl[4], ctl_s}; // RULE7 RULE9
      ppp_pkg::ADDR_INVALID: next_rd = 8'h00; // RULE13
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      host_data_out <= 8'h00;
    end else begin
      host_data_out <= next_rd; // RULE2
    end
  end

  assign host_data_oe = !sel_n_s && !rd_n_s; // RULE1

  //////////////////////////////////////////////////////////////////////////
  // checks
  // a write strobe seen low with the port selected, then seen high
  sequence wr_low_s;
    !sel_n_s && !wr_n_s;
  endsequence

  sequence wr_release_s;
    wr_low_s ##1 (!sel_n_s && wr_n_s);
  endsequence

  // a read strobe seen low with the port selected
  sequence rd_active_s;
    !sel_n_s && !rd_n_s;
  endsequence

  data_store_a: assert property (@(posedge mclk) disable iff (reset) // RULE4
    (wr_fire && addr == ppp_pkg::ADDR_DATA) |=> pdata_out == $past(host_data_in))
    else $error("data write not stored");
  ctl_store_a: assert property (@(posedge mclk) disable iff (reset) // RULE10
    (wr_fire && addr == ppp_pkg::ADDR_CONTROL) |=> ctl == $past(host_data_in[4:0]))
    else $error("control write not stored");
  hold_value_a: assert property (@(posedge mclk) disable iff (reset) // RULE13
    !(wr_fire && addr == ppp_pkg::ADDR_DATA) |=> $stable(out_data))
    else $error("data changed without write");
  deselect_quiet_a: assert property (@(posedge mclk) disable iff (reset) // RULE1
    sel_n_s |-> !host_data_oe && !wr_fire)
    else $error("access while deselected");
  status_ones_a: assert property (@(posedge mclk) disable iff (reset) // RULE5
    !$past(reset) && $past(addr) == ppp_pkg::ADDR_STATUS |-> host_data_out[2:0] == 3'h7)
    else $error("status low bits not one");
  ctl_ones_a: assert property (@(posedge mclk) disable iff (reset) // RULE9
    !$past(reset) && $past(addr) == ppp_pkg::ADDR_CONTROL |-> host_data_out[7:5] == 3'h7)
    else $error("control high bits not one");
  float_pins_a: assert property (@(posedge mclk) disable iff (reset) // RULE11
    oe_n_s |-> !pdata_oe && !pctl_oe)
    else $error("pins driven while disabled");
  irq_gate_a: assert property (@(posedge mclk) disable iff (reset) // RULE8
    !ctl[ppp_pkg::CTL_IRQ_EN] |=> !printer_interrupt)
    else $error("interrupt while disabled");
  write_edge_a: assert property (@(posedge mclk) disable iff (reset) // RULE12
    wr_release_s |-> wr_fire)
    else $error("write release missed");

  // read path: each field of the registered read word against its source
  read_drive_a: assert property (@(posedge mclk) disable iff (reset) // RULE1
    rd_active_s |-> host_data_oe)
    else $error("read select not driven");
  data_read_a: assert property (@(posedge mclk) disable iff (reset) // RULE3
    !$past(reset) && $past(addr) == ppp_pkg::ADDR_DATA |-> host_data_out == $past(data_s))
    else $error("data read differs from lines");
  status_map_a: assert property (@(posedge mclk) disable iff (reset) // RULE6
    !$past(reset) && $past(addr) == ppp_pkg::ADDR_STATUS
    |-> host_data_out[7:3] == $past(sts_s))
    else $error("status read differs from lines");
  ctl_read_a: assert property (@(posedge mclk) disable iff (reset) // RULE7 RULE8
    !$past(reset) && $past(addr) == ppp_pkg::ADDR_CONTROL
    |-> host_data_out[4:0] == {$past(ctl[ppp_pkg::CTL_IRQ_EN]), $past(ctl_s)})
    else $error("control read differs from lines");

  // write path: nothing but a control write moves the control register
  ctl_hold_a: assert property (@(posedge mclk) disable iff (reset) // RULE13
    !(wr_fire && addr == ppp_pkg::ADDR_CONTROL) |=> $stable(ctl))
    else $error("control changed without write");
  bad_write_a: assert property (@(posedge mclk) disable iff (reset) // RULE2 RULE13
    wr_fire && (addr == ppp_pkg::ADDR_STATUS || addr == ppp_pkg::ADDR_INVALID)
    |=> $stable(out_data) && $stable(ctl))
    else $error("invalid write changed state");

  // interrupt pin: follows the gated acknowledge and floats with the port
  irq_follow_a: assert property (@(posedge mclk) disable iff (reset) // RULE8
    ctl[ppp_pkg::CTL_IRQ_EN] && sts_s[ppp_pkg::STS_ACK-3] |=> printer_interrupt)
    else $error("enabled interrupt not raised");
  irq_float_a: assert property (@(posedge mclk) disable iff (reset) // RULE11
    oe_n_s |=> !printer_interrupt_oe)
    else $error("interrupt driven while disabled");
endmodule

// [dv/ppp_printer.sv]
`timescale 1ns/1ns
// printer end of the cable: resolves the shared lines
module ppp_printer (
  input  wire logic [7:0] pdata_out, // port data drive
  input  wire logic       pdata_oe,  // port data enable
  input  wire logic [3:0] pctl_out,  // port control drive
  input  wire logic       pctl_oe,   // port control enable
  input  wire logic [7:0] peer_data, // byte offered by the printer
  input  wire logic [4:0] peer_stat, // busy,ack,paper,select,error
  output logic      [7:0] pdata_in,  // resolved data lines
  output logic      [3:0] pctl_in,   // resolved control lines
  output logic      [4:0] stat       // status lines
);
  // printer only drives data while the port floats, so no contention
  assign pdata_in = pdata_oe ? pdata_out : peer_data;
  // cable pull-ups hold released control lines high
  assign pctl_in = pctl_oe ? pctl_out : 4'hf;
  assign stat = peer_stat;
endmodule

// [dv/ppp_port_tb_top.sv]
`timescale 1ns/1ns
module ppp_port_tb_top;
  logic        mclk, reset, sel_n, rd_n, wr_n, oe_n, pdoe, pcoe, irq, irq_oe, hdoe;
  logic [1:0]  addr;
  logic [7:0]  wdata, rdata, pdo, pdi, peer_data;
  logic [3:0]  pco, pci;
  logic [4:0]  peer_stat, stat;
  logic [31:0] lfsr;
  int          num_errors, checks_done;
  ////////////////////////////////////////////////////////////////////////////
  ppp_port u_dut (.mclk(mclk), .reset(reset), .printer_port_select_n(sel_n),
    .addr(addr), .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
    .host_data_in(wdata), .host_data_out(rdata), .host_data_oe(hdoe),
    .pdata_in(pdi), .pdata_out(pdo), .pdata_oe(pdoe), .pctl_out(pco),
    .pctl_oe(pcoe), .pctl_in(pci), .error_line(stat[0]), .select_line(stat[1]),
    .paper_end_line(stat[2]), .ack_line(stat[3]), .busy_line(stat[4]),
    .printer_output_enable_n(oe_n), .printer_interrupt(irq),
    .printer_interrupt_oe(irq_oe));
  ppp_printer u_prn (.pdata_out(pdo), .pdata_oe(pdoe), .pctl_out(pco),
    .pctl_oe(pcoe), .peer_data(peer_data), .peer_stat(peer_stat),
    .pdata_in(pdi), .pctl_in(pci), .stat(stat));
  ////////////////////////////////////////////////////////////////////////////
  // free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask
  // the write strobe stays low 6 cycles; write is taken at release, so wait it out
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic s);
    @(posedge mclk);
    sel_n <= s;
    addr <= a;
    wdata <= d;
    wr_n <= 1'b0;
    idle(6);
    wr_n <= 1'b1;
    idle(2);
    sel_n <= 1'b1;
    idle(6);
    #1;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    sel_n <= 1'b0;
    addr <= a;
    rd_n <= 1'b0;
    idle(8);
    #1;
    d = rdata;
    check1(hdoe, 1'b1);
    @(posedge mclk);
    rd_n <= 1'b1;
    idle(1);
    sel_n <= 1'b1;
    idle(6);
    #1;
    check1(hdoe, 1'b0);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: the tests need about 1500 cycles
  initial begin
    idle(20000);
    num_errors++;
    $display("ERROR %0t: timeout", $time);
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] r, d;
    logic [4:0] c;
    {reset, sel_n, rd_n, wr_n, addr, wdata, oe_n} = {4'hf, 10'h000, 1'b0};
    {peer_data, peer_stat, lfsr, num_errors, checks_done} = {13'h0000, 32'h6548_c4f9, 64'h0};
    idle(2);
    reset <= 1'b0;
    idle(6);
    rd(ppp_pkg::ADDR_CONTROL, r);
    check8(r, 8'he0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lfsr[7:0];
      c = lfsr[12:8];
      peer_stat <= lfsr[20:16];
      wr(ppp_pkg::ADDR_DATA, d, 1'b0);
      check8(pdo, d);
      rd(ppp_pkg::ADDR_DATA, r);
      check8(r, d);
      wr(ppp_pkg::ADDR_CONTROL, {3'h0, c}, 1'b0);
      check8({4'h0, pco}, {4'h0, c[3:0]});
      rd(ppp_pkg::ADDR_CONTROL, r);
      check8(r, {3'h7, c});
      rd(ppp_pkg::ADDR_STATUS, r);
      check8(r, {lfsr[20:16], 3'h7});
      // stray writes: wrong places and deselected port
      wr(ppp_pkg::ADDR_STATUS, ~d, 1'b0);
      wr(ppp_pkg::ADDR_INVALID, ~d, 1'b0);
      wr(ppp_pkg::ADDR_DATA, ~d, 1'b1);
      rd(ppp_pkg::ADDR_DATA, r);
      check8(r, d);
      rd(ppp_pkg::ADDR_CONTROL, r);
      check8(r, {3'h7, c});
      rd(ppp_pkg::ADDR_INVALID, r);
      check8(r, 8'h00);
    end
    $display("test random access done");
    peer_stat <= 5'h08;
    wr(ppp_pkg::ADDR_CONTROL, 8'h10, 1'b0);
    check1(irq, 1'b1);
    wr(ppp_pkg::ADDR_CONTROL, 8'h00, 1'b0);
    check1(irq, 1'b0);
    $display("test interrupt done");
    oe_n <= 1'b1;
    peer_data <= 8'h5a;
    idle(6);
    check1(pdoe | pcoe | irq_oe, 1'b0);
    rd(ppp_pkg::ADDR_DATA, r);
    check8(r, 8'h5a);
    rd(ppp_pkg::ADDR_CONTROL, r);
    check8(r, 8'hef);
    $display("test float done");
    final_report();
  end
endmodule
